// file: hdl/ingress_fc_regs.svh
`ifndef INGRESS_FC_REGS_SVH
`define INGRESS_FC_REGS_SVH
// watermark limits in kB (1 kB = 1024 bytes)
`define WM_LOW_MIN_KB 7'd10
`define WM_LOW_MAX_KB 7'd74
`define WM_HIGH_MIN_KB 7'd11
`define WM_HIGH_MAX_KB 7'd75
// reset values of the provisioning
`define WM_LOW_RESET_KB 7'd10
`define WM_HIGH_RESET_KB 7'd75
`define FC_EN_RESET 1'b1
`define AN_EN_RESET 1'b1
// fixed pause duration carried in every generated pause frame (quanta)
`define PAUSE_TIME_QUANTA 16'hffff
// fixed pause repetition rate, frames per second
`define PAUSE_RATE_PER_S 32'd1000
// clock rate in hertz
`define CLK_HZ 32'd20000000
// one pause quantum is 512 bit times at 1 Gb/s = 512 ns
`define QUANTUM_NS 32'd512
`define CLK_PERIOD_NS 32'd50
// cycles per quantum, rounded up (a least time)
`define QUANTUM_CYC ((`QUANTUM_NS + `CLK_PERIOD_NS - 32'd1) / `CLK_PERIOD_NS)
// cycles between generated pause frames
`define PAUSE_PERIOD_CYC (`CLK_HZ / `PAUSE_RATE_PER_S)
// mac control ethertype and pause opcode
`define MAC_CTRL_TYPE 16'h8808
`define PAUSE_OPCODE 16'h0001
`endif

// file: hdl/ingress_fc_pkg.sv
package ingress_fc_pkg;
  // flow control mode agreed by autonegotiation
  typedef enum logic [1:0] {
    FC_NONE = 2'b00,
    FC_SYM = 2'b01,
    FC_ASYM = 2'b10,
    FC_FAIL = 2'b11
  } fc_mode_t;
  // provisioning from management
  typedef struct packed {
    logic fc_en;
    logic an_en;
    logic [6:0] wm_low_kb;
    logic [6:0] wm_high_kb;
  } prov_t;
  // pause abilities: bit0 symmetric, bit1 asymmetric
  typedef struct packed {
    logic asym;
    logic sym;
  } pause_abil_t;
  // received frame header seen by the classifier
  typedef struct packed {
    logic [15:0] ethertype;
    logic [15:0] opcode;
    logic [15:0] quanta;
  } ctrl_hdr_t;
endpackage : ingress_fc_pkg

// file: hdl/ingress_fc.sv
`timescale 1ns/1ps
`include "ingress_fc_regs.svh"
module ingress_fc
  import ingress_fc_pkg::*;
#(
  parameter int BUF_BYTES = 77824, // buffer size in bytes (76 kB)
  parameter int OCC_W = 17, // occupancy counter width
  parameter int PAUSE_PERIOD = `PAUSE_PERIOD_CYC // cycles between pauses
) (
  input wire logic clk, // 20 MHz clock
  input wire logic rstn, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic prov_wr, // one-cycle provisioning write strobe
  input wire prov_t prov_in, // provisioning value to write
  output prov_t prov_out, // provisioning in force
  output logic prov_err, // last write refused (range or order)
  input wire logic an_done, // autonegotiation finished
  input wire pause_abil_t peer_abil, // abilities the peer advertised
  output pause_abil_t adv_abil, // abilities we advertise
  output logic full_duplex, // always full duplex
  output fc_mode_t fc_mode, // resolved flow control mode
  output logic tx_disable, // transmitter off
  input wire logic rx_sof, // ingress frame starts
  input wire logic rx_valid, // ingress byte valid
  input wire logic rx_eof, // ingress frame ends, with last byte
  input wire logic [10:0] rx_len, // frame length estimate at start
  input wire ctrl_hdr_t rx_hdr, // header of frame at rx_sof
  output logic rx_drop, // frame dropped (tail drop or pause)
  input wire logic deq, // one byte leaves the buffer toward egress
  output logic [OCC_W-1:0] occupancy, // buffer bytes in use
  output logic pause_req, // one-cycle request to send a pause frame
  output logic [15:0] pause_quanta, // duration carried in that frame
  output logic pausing, // generator active
  input wire logic tx_busy, // egress frame in progress
  input wire logic tx_ready, // egress has a frame to start
  output logic tx_start, // permission to start a new frame
  output logic tx_paused // transmit held by received pause
);
  // ===========================================================
  // provisioning
  // ===========================================================
  prov_t prov_reg, prov_next;
  logic err_reg, err_next;
  logic ok;
  // check ranges and ordering before accepting a write
  always_comb begin
    ok = (prov_in.wm_low_kb >= `WM_LOW_MIN_KB) &&
         (prov_in.wm_low_kb <= `WM_LOW_MAX_KB) &&
         (prov_in.wm_high_kb >= `WM_HIGH_MIN_KB) &&
         (prov_in.wm_high_kb <= `WM_HIGH_MAX_KB) &&
         (prov_in.wm_low_kb < prov_in.wm_high_kb);
    prov_next = prov_reg;
    err_next = err_reg;
    if (prov_wr) begin
      err_next = !ok;
      if (ok) begin
        prov_next = prov_in;
      end
    end
  end
  // register provisioning; enables default on, kept across link restarts
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prov_reg <= '{fc_en: `FC_EN_RESET, an_en: `AN_EN_RESET,
                    wm_low_kb: `WM_LOW_RESET_KB,
                    wm_high_kb: `WM_HIGH_RESET_KB};
      err_reg <= 1'b0;
    end else if (ce) begin
      prov_reg <= prov_next;
      err_reg <= err_next;
    end
  end
  assign prov_out = prov_reg;
  assign prov_err = err_reg;

  // ===========================================================
  // autonegotiation resolution
  // ===========================================================
  fc_mode_t mode_reg, mode_next;
  // advertise all supported modes only with flow control on
  assign adv_abil = prov_reg.fc_en ? 2'b11 : 2'b00;
  assign full_duplex = 1'b1;
  // resolve the common mode when negotiation ends
  always_comb begin
    mode_next = mode_reg;
    if (!prov_reg.fc_en) begin
      mode_next = FC_NONE;
    end else if (!prov_reg.an_en) begin
      mode_next = FC_SYM; // forced mode without negotiation
    end else if (an_done) begin
      if (peer_abil.sym) begin
        mode_next = FC_SYM;
      end else if (peer_abil.asym) begin
        mode_next = FC_ASYM;
      end else begin
        mode_next = FC_FAIL;
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= FC_NONE;
    end else if (ce) begin
      mode_reg <= mode_next;
    end
  end
  assign fc_mode = mode_reg;
  assign tx_disable = (mode_reg == FC_FAIL);

  // ===========================================================
  // ingress buffer accounting and tail drop
  // ===========================================================
  logic [OCC_W-1:0] occ_reg, occ_next;
  logic drop_reg, drop_next;
  logic in_frame_reg, in_frame_next;
  logic is_pause, fits, gen_ok;
  logic [OCC_W-1:0] room;
  // a pause frame is terminated here, never buffered
  assign is_pause = (rx_hdr.ethertype == `MAC_CTRL_TYPE) &&
                    (rx_hdr.opcode == `PAUSE_OPCODE);
  always_comb begin
    room = OCC_W'(BUF_BYTES) - occ_reg;
    fits = (OCC_W'(rx_len) <= room);
    occ_next = occ_reg;
    drop_next = drop_reg;
    in_frame_next = in_frame_reg;
    if (rx_sof) begin
      // newest frame is the one refused when no room: tail drop
      drop_next = is_pause || !fits;
      // a one-byte frame opens and closes in the same cycle
      in_frame_next = !(rx_valid && rx_eof);
    end else if (rx_valid && rx_eof) begin
      in_frame_next = 1'b0;
    end
    // store each accepted byte that finds the buffer not full until egress takes it; stray bytes
    // outside a frame are not stored
    if (rx_valid && (rx_sof || in_frame_reg) && !drop_next &&
        occ_reg != OCC_W'(BUF_BYTES)) begin
      occ_next = occ_next + 1'b1;
    end
    if (deq && occ_next != '0) begin
      occ_next = occ_next - 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      occ_reg <= '0;
      drop_reg <= 1'b0;
      in_frame_reg <= 1'b0;
    end else if (ce) begin
      occ_reg <= occ_next;
      drop_reg <= drop_next;
      in_frame_reg <= in_frame_next;
    end
  end
  assign occupancy = occ_reg;
  assign rx_drop = drop_reg;

  // ===========================================================
  // pause generation with hysteresis
  // ===========================================================
  logic gen_reg, gen_next;
  logic [31:0] gcnt_reg, gcnt_next;
  logic req_reg, req_next;
  logic above_hi, below_lo;
  assign gen_ok = (mode_reg == FC_SYM) || (mode_reg == FC_ASYM);
  assign above_hi = occ_reg > {prov_reg.wm_high_kb, 10'h000};
  assign below_lo = occ_reg < {prov_reg.wm_low_kb, 10'h000};
  always_comb begin
    gen_next = gen_reg;
    gcnt_next = gcnt_reg;
    req_next = 1'b0;
    if (!gen_ok) begin
      gen_next = 1'b0;
    end else if (!gen_reg && above_hi) begin
      gen_next = 1'b1;
      gcnt_next = '0;
    end else if (gen_reg && below_lo) begin
      gen_next = 1'b0;
    end
    if (gen_next) begin
      // fixed repetition period; hazard: rate not software set
      // a fresh activation pulses at once, whatever count a stop left
      if (!gen_reg || gcnt_reg == 32'd0) begin
        req_next = 1'b1;
        gcnt_next = 32'(PAUSE_PERIOD - 1);
      end else begin
        gcnt_next = gcnt_reg - 32'd1;
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gen_reg <= 1'b0;
      gcnt_reg <= '0;
      req_reg <= 1'b0;
    end else if (ce) begin
      gen_reg <= gen_next;
      gcnt_reg <= gcnt_next;
      req_reg <= req_next;
    end
  end
  assign pause_req = req_reg;
  assign pause_quanta = `PAUSE_TIME_QUANTA;
  assign pausing = gen_reg;

  // ===========================================================
  // received pause: hold new transmit frames
  // ===========================================================
  logic [15:0] q_reg, q_next;
  logic [5:0] sub_reg, sub_next;
  logic obey;
  assign obey = (mode_reg == FC_SYM);
  // the peer is trusted to quiet for our pause time
  always_comb begin
    q_next = q_reg;
    sub_next = sub_reg;
    if (rx_sof && is_pause && obey) begin
      q_next = rx_hdr.quanta;
      sub_next = 6'(`QUANTUM_CYC - 1);
    end else if (!obey) begin
      q_next = '0;
    end else if (q_reg != '0) begin
      if (sub_reg == '0) begin
        q_next = q_reg - 16'd1;
        sub_next = 6'(`QUANTUM_CYC - 1);
      end else begin
        sub_next = sub_reg - 6'd1;
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_reg <= '0;
      sub_reg <= '0;
    end else if (ce) begin
      q_reg <= q_next;
      sub_reg <= sub_next;
    end
  end
  assign tx_paused = (q_reg != '0);
  // a frame already in progress is untouched; only new starts wait
  assign tx_start = tx_ready && !tx_busy && !tx_paused &&
                    !tx_disable;
endmodule : ingress_fc

// file: test/ingress_fc_checker.sv
`timescale 1ns/1ps
// ==================================================
// port checker for the ingress flow control block
module ingress_fc_checker
  import ingress_fc_pkg::*;
#(
  parameter int OCC_W = 17 // occupancy width, as the design
) (
  input wire logic clk, // block clock
  input wire logic rstn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic prov_wr, // provisioning write
  input wire prov_t prov_in, // value written
  input wire prov_t prov_out, // value in force
  input wire logic prov_err, // write refused
  input wire pause_abil_t adv_abil, // advertised abilities
  input wire logic full_duplex, // duplex mode
  input wire fc_mode_t fc_mode, // resolved mode
  input wire logic tx_disable, // transmitter off
  input wire logic rx_sof, // frame start
  input wire ctrl_hdr_t rx_hdr, // frame header
  input wire logic rx_drop, // frame dropped
  input wire logic [OCC_W-1:0] occupancy, // bytes buffered
  input wire logic pause_req, // pause frame request
  input wire logic [15:0] pause_quanta, // pause duration
  input wire logic pausing, // generator active
  input wire logic tx_ready, // egress wants to start
  input wire logic tx_busy, // egress frame running
  input wire logic tx_paused, // held by peer pause
  input wire logic tx_start // start permission
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // a write outside the legal ranges or with low not below high
  wire bad = prov_in.wm_low_kb < 7'd10 || prov_in.wm_low_kb > 7'd74 ||
    prov_in.wm_high_kb < 7'd11 || prov_in.wm_high_kb > 7'd75 ||
    prov_in.wm_low_kb >= prov_in.wm_high_kb;
  wire is_pause = rx_hdr.ethertype == 16'h8808 && rx_hdr.opcode == 16'h0001;
  // ==================================================
  // assertions
  a_refuse_bad: assert property (ce && prov_wr && bad |=>
    prov_err && prov_out == $past(prov_out)) else $error("bad write taken");
  a_accept_good: assert property (ce && prov_wr && !bad |=>
    !prov_err && prov_out == $past(prov_in)) else $error("good write lost");
  a_wm_order: assert property (
    prov_out.wm_low_kb < prov_out.wm_high_kb)
    else $error("watermarks out of order");
  a_fixed_pause: assert property (
    pause_quanta == 16'hffff && full_duplex)
    else $error("pause duration or duplex changed");
  a_pause_gap: assert property (pause_req |=> !pause_req [*8])
    else $error("pause frames too close");
  a_pause_begin: assert property (
    $rose(pausing) |-> ##[0:1] pause_req)
    else $error("no pause frame on activation");
  a_stop_low: assert property (pausing &&
    occupancy < {prov_out.wm_low_kb, 10'h000} |-> ##[1:2] !pausing)
    else $error("pausing below low watermark");
  a_start_gate: assert property (tx_start == (tx_ready && !tx_busy &&
    !tx_paused && !tx_disable)) else $error("start permission wrong");
  a_tx_off: assert property (tx_disable == (fc_mode == FC_FAIL))
    else $error("transmitter state wrong");
  a_adv_all: assert property (adv_abil == {2{prov_out.fc_en}})
    else $error("advertised abilities wrong");
  a_pause_eaten: assert property (
    ce && rx_sof && is_pause |=> rx_drop)
    else $error("pause frame not consumed");
  c_pausing: cover property ($rose(pausing));
  c_paused: cover property ($rose(tx_paused));
  c_refused: cover property (prov_err);
endmodule : ingress_fc_checker
bind ingress_fc ingress_fc_checker #(.OCC_W(OCC_W)) chk_i (
  .clk(clk), .rstn(rstn), .ce(ce), .prov_wr(prov_wr), .prov_in(prov_in),
  .prov_out(prov_out), .prov_err(prov_err), .adv_abil(adv_abil),
  .full_duplex(full_duplex), .fc_mode(fc_mode), .tx_disable(tx_disable),
  .rx_sof(rx_sof), .rx_hdr(rx_hdr), .rx_drop(rx_drop),
  .occupancy(occupancy), .pause_req(pause_req),
  .pause_quanta(pause_quanta), .pausing(pausing), .tx_ready(tx_ready),
  .tx_busy(tx_busy), .tx_paused(tx_paused), .tx_start(tx_start)
);

// file: test/peer_model.sv
`timescale 1ns/1ps
// ==================================================
// attached switch port: sends frames, honours pauses
module peer_model
  import ingress_fc_pkg::*;
#(
  parameter int HOLD = 30 // shortened quiet time per pause
) (
  input wire logic clk, // block clock
  input wire logic pause_req, // pause frame from the device
  output logic rx_sof, // frame start
  output logic rx_valid, // byte valid
  output logic rx_eof, // last byte
  output logic [10:0] rx_len, // frame length
  output ctrl_hdr_t rx_hdr // frame header
);
  int hold = 0; // quiet cycles left
  bit obey = 1'b1; // cleared only to force an overrun
  initial {rx_sof, rx_valid, rx_eof, rx_len, rx_hdr} = '0;
  // every pause restarts the quiet time; quiet ends HOLD cycles after the last pause
  always @(posedge clk)
    hold <= pause_req ? HOLD : (hold > 0 ? hold - 1 : 0);
  // one byte a cycle; the header is garbled outside the start cycle
  task automatic send(input logic [10:0] n, input ctrl_hdr_t h);
    @(posedge clk);
    while (obey && hold > 0) @(posedge clk);
    rx_sof <= 1'b1;
    rx_len <= n;
    rx_hdr <= h;
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_eof <= (i == n - 1);
      @(posedge clk);
      rx_sof <= 1'b0;
      rx_hdr <= ~h;
    end
    rx_valid <= 1'b0;
    rx_eof <= 1'b0;
  endtask : send
endmodule : peer_model

// file: test/testbench.sv
`timescale 1ns/1ps
// ==================================================
// bench for the ingress flow control block
module testbench;
  import ingress_fc_pkg::*;
  localparam int BUF = 12288; // 12 kB buffer keeps the run short
  logic clk = 0, rstn = 0, ce = 1, prov_wr = 0, an_done = 0;
  logic tx_busy = 0, tx_ready = 1, deq = 0;
  logic prov_err, full_duplex, tx_disable, rx_sof, rx_valid, rx_eof;
  logic rx_drop, pause_req, pausing, tx_start, tx_paused;
  logic [10:0] rx_len;
  logic [16:0] occupancy;
  logic [15:0] pause_quanta;
  prov_t prov_in = '0, prov_out;
  prov_t cur = {1'b1, 1'b1, 7'd10, 7'd75}; // expected provisioning
  pause_abil_t peer_abil = '0, adv_abil;
  fc_mode_t fc_mode;
  ctrl_hdr_t rx_hdr;
  int err_total = 0, checks_done = 0;
  int preq_cnt = 0, n0 = 0; // pause requests seen, window start
  // count pause requests to check the fixed repetition rate
  always @(posedge clk) if (pause_req) preq_cnt <= preq_cnt + 1;
  `define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
    err_total++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
  ingress_fc #(.BUF_BYTES(BUF), .PAUSE_PERIOD(20)) ingress_fc_i (
    .clk(clk), .rstn(rstn), .ce(ce), .prov_wr(prov_wr), .prov_in(prov_in),
    .prov_out(prov_out), .prov_err(prov_err), .an_done(an_done),
    .peer_abil(peer_abil), .adv_abil(adv_abil), .full_duplex(full_duplex),
    .fc_mode(fc_mode), .tx_disable(tx_disable), .rx_sof(rx_sof),
    .rx_valid(rx_valid), .rx_eof(rx_eof), .rx_len(rx_len), .rx_hdr(rx_hdr),
    .rx_drop(rx_drop), .deq(deq), .occupancy(occupancy),
    .pause_req(pause_req), .pause_quanta(pause_quanta), .pausing(pausing),
    .tx_busy(tx_busy), .tx_ready(tx_ready), .tx_start(tx_start),
    .tx_paused(tx_paused)
  );
  peer_model peer_i (
    .clk(clk), .pause_req(pause_req), .rx_sof(rx_sof), .rx_valid(rx_valid),
    .rx_eof(rx_eof), .rx_len(rx_len), .rx_hdr(rx_hdr)
  );
  initial forever #25 clk = ~clk;
  // ==================================================
  // tasks
  task automatic prov(input prov_t v, input logic e);
    @(posedge clk) prov_wr <= 1'b1;
    prov_in <= v;
    @(posedge clk) prov_wr <= 1'b0;
    #1;
    if (!e) cur = v;
    `CHK(prov_err, e)
    `CHK(prov_out, cur)
  endtask : prov
  // set enables, present peer abilities, check the resolved mode
  task automatic mode(input logic [1:0] fa, input pause_abil_t p,
                      input fc_mode_t m);
    prov({fa, 7'd10, 7'd11}, 1'b0);
    @(posedge clk) peer_abil <= p;
    repeat (2) @(posedge clk);
    #1;
    `CHK(fc_mode, m)
    `CHK(tx_start, m != FC_FAIL)
    `CHK(tx_disable, m == FC_FAIL)
    `CHK(adv_abil, {2{fa[1]}})
  endtask : mode
  task automatic pause_in(input logic [15:0] q);
    peer_i.send(11'd64, {16'h8808, 16'h0001, q});
    #1;
    `CHK(rx_drop, 1'b1)
  endtask : pause_in
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // ==================================================
  // test sequence
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    an_done <= 1'b1;
    @(posedge clk) #1;
    `CHK(prov_out, cur)
    `CHK(full_duplex, 1'b1)
    `CHK(pause_quanta, 16'hffff)
    prov({2'b11, 7'd9, 7'd75}, 1'b1);
    prov({2'b11, 7'd10, 7'd76}, 1'b1);
    prov({2'b11, 7'd40, 7'd40}, 1'b1);
    prov({2'b11, 7'd74, 7'd75}, 1'b0);
    mode(2'b11, 2'b00, FC_FAIL);
    mode(2'b01, 2'b11, FC_NONE);
    mode(2'b10, 2'b00, FC_SYM);
    mode(2'b11, 2'b10, FC_ASYM);
    pause_in(16'd20);
    `CHK(tx_paused, 1'b0)
    mode(2'b11, 2'b11, FC_SYM);
    pause_in(16'd20);
    `CHK(tx_start, 1'b0)
    pause_in(16'd20);
    repeat (120) @(posedge clk) #1;
    `CHK(tx_paused, 1'b1)
    repeat (50) @(posedge clk) #1;
    `CHK(tx_start, 1'b1)
    // a frame in progress blocks a new start
    @(posedge clk) tx_busy <= 1'b1;
    #1;
    `CHK(tx_start, 1'b0)
    @(posedge clk) tx_busy <= 1'b0;
    `CHK(occupancy, 17'd0)
    repeat (12) peer_i.send(11'd1024, '0);
    #1;
    `CHK(occupancy, 17'd12288)
    `CHK(rx_drop, 1'b0)
    `CHK(pausing, 1'b1)
    peer_i.obey = 1'b0;
    peer_i.send(11'd1024, '0);
    peer_i.obey = 1'b1;
    #1;
    `CHK(occupancy, 17'd12288)
    `CHK(rx_drop, 1'b1)
    // 100 cycles hold exactly five requests at a period of 20
    n0 = preq_cnt;
    repeat (100) @(posedge clk);
    #1;
    `CHK(preq_cnt - n0, 5)
    @(posedge clk) deq <= 1'b1;
    repeat (2048) @(posedge clk);
    #1;
    `CHK(pausing, 1'b1)
    @(posedge clk) deq <= 1'b0;
    repeat (3) @(posedge clk) #1;
    `CHK(occupancy, 17'd10239)
    `CHK(pausing, 1'b0)
    end_sim();
  end
  // the sequence needs about 16000 cycles
  initial begin
    #2000000;
    err_total++;
    end_sim();
  end
endmodule : testbench
